/* File: rtl/i2cfm_pkg.sv */
// Behaviour
// - first bus port offers Fast Mode Plus
// - pad bit 0 selects data drive
// - pad bit 1 disables data filtering
// - pad bit 2 selects clock drive
// - pad bit 3 disables clock filtering
// - match four 7-bit addresses and general call
// - address match raises interrupt request
// - four address and four mask registers
// - monitor mode observes, never disturbs lines
// - monitor raises interrupt on every address
// - monitor control and data buffer registers
package i2cfm_pkg;
  // ****************************************************
  // register offsets
  // ****************************************************
  localparam logic [7:0] OFS_PAD    = 8'h00;
  localparam logic [7:0] OFS_ADR0   = 8'h04;
  localparam logic [7:0] OFS_MSK0   = 8'h14;
  localparam logic [7:0] OFS_MON    = 8'h24;
  localparam logic [7:0] OFS_DBUF   = 8'h28;
  localparam logic [7:0] OFS_STAT   = 8'h2C;
  localparam logic [7:0] OFS_LAST   = 8'h30;
  // ****************************************************
  // fields and reset values
  // ****************************************************
  localparam int PAD_SDA_DRV  = 0;
  localparam int PAD_SDA_FLT  = 1;
  localparam int PAD_SCL_DRV  = 2;
  localparam int PAD_SCL_FLT  = 3;
  localparam int PAD_WIDTH    = 4;
  localparam int MON_SLV_EN   = 0;
  localparam int MON_MON_EN   = 1;
  localparam int MON_GC_EN    = 2;
  localparam int MON_WIDTH    = 3;
  localparam int ST_ADDR_EV   = 0;
  localparam int ST_OVFL      = 1;
  localparam logic [3:0] PAD_RESET = 4'h0;
  localparam logic [2:0] MON_RESET = 3'h0;
  localparam logic [7:0] ADR_RESET = 8'h00;
  localparam logic [6:0] MSK_RESET = 7'h00;
  localparam int NUM_ADDR     = 4;
  localparam logic [6:0] GEN_CALL = 7'h00;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ****************************************************
  // link state
  // ****************************************************
  typedef enum logic [3:0] {
    LS_IDLE = 4'b0001,
    LS_BYTE = 4'b0010,
    LS_ACK  = 4'b0100,
    LS_SKIP = 4'b1000
  } i2cfm_link_t;
endpackage : i2cfm_pkg

/* File: rtl/i2cfm_fifo.sv */
`timescale 1ns/1ps
module i2cfm_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // clock and reset
  input  wire logic             aclk,
  input  wire logic             aresetn,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin
      $error("fifo depth must be a power of two");
    end
  end
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wp_q;
  logic [AW-1:0]    rp_q;
  logic [AW:0]      cnt_q;
  logic             push;
  logic             pop;
  assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem_q[rp_q];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  always_ff @(posedge aclk) begin
    if (push) begin
      mem_q[wp_q] <= in_data;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wp_q <= wp_q + 1'b1;
      end
      if (pop) begin
        rp_q <= rp_q + 1'b1;
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop && !push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
  fifo_bound_a: assert property (@(posedge aclk) disable iff (!aresetn)
    cnt_q <= (AW+1)'(DEPTH))
    else $error("fifo count beyond depth");
endmodule : i2cfm_fifo

/* File: rtl/i2cfm_top.sv */
// Chosen here: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps
module i2cfm_top
  import i2cfm_pkg::*;
#(
  parameter int FIFO_DEPTH = 16
) (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite write
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // two-wire bus pins
  input  wire logic        scl_i,
  output logic             scl_o,
  output logic             scl_oe,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe,
  // pad controls
  output logic             data_line_drive_select,
  output logic             data_line_filter_disable,
  output logic             clock_line_drive_select,
  output logic             clock_line_filter_disable,
  // events
  output logic             irq
);
  // ****************************************************
  // registers
  // ****************************************************
  logic [PAD_WIDTH-1:0] pad_q;
  logic [7:0]           adr_q [NUM_ADDR];
  logic [6:0]           msk_q [NUM_ADDR];
  logic [MON_WIDTH-1:0] mon_q;
  logic [1:0]           stat_q;
  logic [7:0]           last_q;
  logic                 aw_hold_q;
  logic                 w_hold_q;
  logic [7:0]           awaddr_q;
  logic [31:0]          wdata_q;
  logic [3:0]           wstrb_q;
  logic                 wr_go;
  logic                 rd_go;
  logic                 addr_event;
  logic                 ovfl_event;
  logic                 fifo_in_valid;
  logic                 fifo_in_ready;
  logic [7:0]           fifo_in_data;
  logic                 fifo_out_valid;
  logic                 fifo_out_ready;
  logic [7:0]           fifo_out_data;

  function automatic logic addr_hit(input logic [6:0] rx,
                                    input logic [7:0] adr,
                                    input logic [6:0] msk);
    addr_hit = adr[0] && (((rx ^ adr[7:1]) & ~msk) == 7'h00);
  endfunction : addr_hit

  // ****************************************************
  // axi4-lite write path
  // ****************************************************
  assign s_axi_awready = !aw_hold_q && !s_axi_bvalid;
  assign s_axi_wready  = !w_hold_q && !s_axi_bvalid;
  assign wr_go         = aw_hold_q && w_hold_q && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q <= 1'b0;
      w_hold_q  <= 1'b0;
      awaddr_q  <= 8'h00;
      wdata_q   <= 32'h0000_0000;
      wstrb_q   <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr;
      end else if (wr_go) begin
        aw_hold_q <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
      end else if (wr_go) begin
        w_hold_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (awaddr_q[7:2] <= OFS_LAST[7:2]) ? RESP_OKAY
                                                      : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // pad bits: only the low byte lane carries them
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pad_q <= PAD_RESET;
    end else if (wr_go && awaddr_q == OFS_PAD && wstrb_q[0]) begin
      pad_q <= wdata_q[PAD_WIDTH-1:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mon_q <= MON_RESET;
    end else if (wr_go && awaddr_q == OFS_MON && wstrb_q[0]) begin
      mon_q <= wdata_q[MON_WIDTH-1:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < NUM_ADDR; i++) begin
        adr_q[i] <= ADR_RESET;
        msk_q[i] <= MSK_RESET;
      end
    end else if (wr_go && wstrb_q[0]) begin
      for (int i = 0; i < NUM_ADDR; i++) begin
        if (awaddr_q == OFS_ADR0 + 8'(4 * i)) begin
          adr_q[i] <= wdata_q[7:0];
        end
        if (awaddr_q == OFS_MSK0 + 8'(4 * i)) begin
          msk_q[i] <= wdata_q[7:1];
        end
      end
    end
  end

  // sticky status, write one to clear, a new event wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stat_q <= 2'h0;
    end else begin
      if (wr_go && awaddr_q == OFS_STAT && wstrb_q[0]) begin
        stat_q <= stat_q & ~wdata_q[1:0];
      end
      if (addr_event) begin
        stat_q[ST_ADDR_EV] <= 1'b1;
      end
      if (ovfl_event) begin
        stat_q[ST_OVFL] <= 1'b1;
      end
    end
  end
  assign irq = stat_q[ST_ADDR_EV];

  assign data_line_drive_select    = pad_q[PAD_SDA_DRV];
  assign data_line_filter_disable  = pad_q[PAD_SDA_FLT];
  assign clock_line_drive_select   = pad_q[PAD_SCL_DRV];
  assign clock_line_filter_disable = pad_q[PAD_SCL_FLT];

  // ****************************************************
  // axi4-lite read path
  // ****************************************************
  assign s_axi_arready  = !s_axi_rvalid;
  assign rd_go          = s_axi_arvalid && s_axi_arready;
  assign fifo_out_ready = rd_go && s_axi_araddr == OFS_DBUF;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= RESP_OKAY;
    end else if (rd_go) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= RESP_OKAY;
      s_axi_rdata  <= 32'h0000_0000;
      unique case (s_axi_araddr)
        OFS_PAD:  s_axi_rdata[PAD_WIDTH-1:0] <= pad_q;
        OFS_MON:  s_axi_rdata[MON_WIDTH-1:0] <= mon_q;
        OFS_DBUF: s_axi_rdata[8:0] <= {fifo_out_valid, fifo_out_data};
        OFS_STAT: s_axi_rdata[1:0] <= stat_q;
        OFS_LAST: s_axi_rdata[7:0] <= last_q;
        default: begin
          s_axi_rresp <= RESP_SLVERR;
          for (int i = 0; i < NUM_ADDR; i++) begin
            if (s_axi_araddr == OFS_ADR0 + 8'(4 * i)) begin
              s_axi_rdata[7:0] <= adr_q[i];
              s_axi_rresp      <= RESP_OKAY;
            end
            if (s_axi_araddr == OFS_MSK0 + 8'(4 * i)) begin
              s_axi_rdata[7:1] <= msk_q[i];
              s_axi_rresp      <= RESP_OKAY;
            end
          end
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ****************************************************
  // pin synchronisers
  // ****************************************************
  logic [2:0] scl_s_q;
  logic [2:0] sda_s_q;
  logic       scl_f_q;
  logic       sda_f_q;
  logic       scl_rise;
  logic       scl_fall;
  logic       start_c;
  logic       stop_c;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      scl_s_q <= 3'h7;
      sda_s_q <= 3'h7;
      scl_f_q <= 1'b1;
      sda_f_q <= 1'b1;
    end else begin
      scl_s_q <= {scl_s_q[1:0], scl_i};
      sda_s_q <= {sda_s_q[1:0], sda_i};
      if (scl_s_q[1] == scl_s_q[2]) begin
        scl_f_q <= scl_s_q[2];
      end
      if (sda_s_q[1] == sda_s_q[2]) begin
        sda_f_q <= sda_s_q[2];
      end
    end
  end
  assign scl_rise = !scl_f_q && scl_s_q[1] == scl_s_q[2] && scl_s_q[2];
  assign scl_fall = scl_f_q && scl_s_q[1] == scl_s_q[2] && !scl_s_q[2];
  assign start_c  = scl_f_q && sda_f_q && sda_s_q[1] == sda_s_q[2]
                    && !sda_s_q[2];
  assign stop_c   = scl_f_q && !sda_f_q && sda_s_q[1] == sda_s_q[2]
                    && sda_s_q[2];

  // ****************************************************
  // bus follower
  // ****************************************************
  i2cfm_link_t st_q;
  logic [7:0]  sh_q;
  logic [3:0]  bit_q;
  logic        first_q;
  logic        sel_q;
  logic        ack_q;
  logic        hit;
  logic        monitor;
  logic        byte_done;

  assign monitor   = mon_q[MON_MON_EN];
  assign byte_done = st_q == LS_BYTE && bit_q == 4'h8 && scl_fall;

  // any enabled address, masked bits ignored, or general call
  always_comb begin
    hit = mon_q[MON_GC_EN] && sh_q[7:1] == GEN_CALL;
    for (int i = 0; i < NUM_ADDR; i++) begin
      hit = hit || addr_hit(sh_q[7:1], adr_q[i], msk_q[i]);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q    <= LS_IDLE;
      sh_q    <= 8'h00;
      bit_q   <= 4'h0;
      first_q <= 1'b0;
      sel_q   <= 1'b0;
      ack_q   <= 1'b0;
    end else if (start_c) begin
      st_q    <= LS_BYTE;
      bit_q   <= 4'h0;
      first_q <= 1'b1;
      sel_q   <= 1'b0;
      ack_q   <= 1'b0;
    end else if (stop_c) begin
      st_q  <= LS_IDLE;
      sel_q <= 1'b0;
      ack_q <= 1'b0;
    end else begin
      unique case (st_q)
        LS_IDLE: ;
        LS_BYTE: begin
          if (scl_rise && bit_q != 4'h8) begin
            sh_q  <= {sh_q[6:0], sda_f_q};
            bit_q <= bit_q + 4'h1;
          end
          if (byte_done) begin
            st_q <= LS_ACK;
            if (first_q) begin
              sel_q <= hit && !sh_q[0] && mon_q[MON_SLV_EN];
              ack_q <= hit && !sh_q[0] && mon_q[MON_SLV_EN] && !monitor
                       && fifo_in_ready;
            end else begin
              ack_q <= sel_q && !monitor && fifo_in_ready;
            end
          end
        end
        LS_ACK: begin
          if (scl_fall) begin
            ack_q   <= 1'b0;
            first_q <= 1'b0;
            bit_q   <= 4'h0;
            st_q    <= (sel_q || monitor) ? LS_BYTE : LS_SKIP;
          end
        end
        LS_SKIP: ;
      endcase
    end
  end

  // address events: matches in slave mode, every address in monitor mode
  assign addr_event = byte_done && first_q
                      && (monitor || (mon_q[MON_SLV_EN] && hit));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      last_q <= 8'h00;
    end else if (addr_event) begin
      last_q <= sh_q;
    end
  end

  // received bytes go to the buffer; monitor cannot stall the bus
  assign fifo_in_valid = byte_done && (monitor || (sel_q && !first_q));
  assign fifo_in_data  = sh_q;
  assign ovfl_event    = fifo_in_valid && !fifo_in_ready;

  i2cfm_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .in_valid  (fifo_in_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (fifo_in_data),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_out_data)
  );

  // open-drain: data pulled low only during an acknowledge
  assign sda_o  = 1'b0;
  assign sda_oe = ack_q && st_q == LS_ACK && !monitor;
  assign scl_o  = 1'b0;
  assign scl_oe = 1'b0;

  // ****************************************************
  // assertions
  // ****************************************************
  pad_drive_a: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_go && awaddr_q == OFS_PAD && wstrb_q[0]
    |=> data_line_drive_select == $past(wdata_q[0])
        && clock_line_drive_select == $past(wdata_q[2]))
    else $error("pad drive bits not taken");

  pad_filter_a: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_go && awaddr_q == OFS_PAD && wstrb_q[0]
    |=> data_line_filter_disable == $past(wdata_q[1])
        && clock_line_filter_disable == $past(wdata_q[3]))
    else $error("pad filter bits not taken");

  monitor_quiet_a: assert property (@(posedge aclk) disable iff (!aresetn)
    monitor |-> !sda_oe && !scl_oe)
    else $error("monitor mode drives the bus");

  monitor_event_a: assert property (@(posedge aclk) disable iff (!aresetn)
    byte_done && first_q && monitor |=> irq)
    else $error("monitor missed an address");

  match_irq_a: assert property (@(posedge aclk) disable iff (!aresetn)
    byte_done && first_q && mon_q[MON_SLV_EN] && hit
    |=> irq && last_q == $past(sh_q))
    else $error("address match gave no request");

  ack_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    sda_oe |-> st_q == LS_ACK && sel_q)
    else $error("acknowledge while not selected");

  write_resp_a: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");

  read_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
endmodule : i2cfm_top

/* File: dv/i2cfm_bus_model.sv */
`timescale 1ns/1ps
// ****
// two-wire bus master model, open drain, lines pulled up
// ****
module i2cfm_bus_model (
  // wire level of the data line
  input  wire logic sda_line,
  // open-drain drives, 1 releases the line
  output logic      scl_drv,
  output logic      sda_drv
);
  // quarter of the 320 ns link period; clock stands high between frames
  localparam time QTR = 80ns;

  initial begin
    scl_drv = 1'b1;
    sda_drv = 1'b1;
  end

  task automatic start_frame();
    #7;
    sda_drv = 1'b0;
    #(2*QTR);
    scl_drv = 1'b0;
  endtask : start_frame

  task automatic send_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      #(QTR);
      sda_drv = b[i];
      #(QTR);
      scl_drv = 1'b1;
      #(2*QTR);
      scl_drv = 1'b0;
    end
    #(QTR);
    sda_drv = 1'b1;
    #(QTR);
    scl_drv = 1'b1;
    // sample late in the high phase to allow for pin synchronisers
    #(150ns);
    ack = sda_line;
    #(10ns);
    scl_drv = 1'b0;
  endtask : send_byte

  task automatic stop_frame();
    #(QTR);
    sda_drv = 1'b0;
    #(QTR);
    scl_drv = 1'b1;
    #(2*QTR);
    sda_drv = 1'b1;
    #(4*QTR);
  endtask : stop_frame
endmodule : i2cfm_bus_model

/* File: dv/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  import i2cfm_pkg::*;
  // ****
  // signals
  // ****
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic        scl_o, scl_oe, sda_o, sda_oe, irq, scl_drv, sda_drv;
  logic [3:0]  pad;
  logic [31:0] rd;
  logic        ack;
  logic        mon_on = 1'b0, touched = 1'b0;
  logic [6:0]  adr_tab [4] = '{7'h12, 7'h2C, 7'h47, 7'h7E};
  wire logic   scl_line, sda_line;
  int          fail_count = 0, total_checks = 0;

  assign scl_line = scl_drv & ~(scl_oe & ~scl_o);
  assign sda_line = sda_drv & ~(sda_oe & ~sda_o);

  always #20 aclk = ~aclk;

  always @(posedge aclk) if (scl_oe || (mon_on && sda_oe)) touched <= 1'b1;

  i2cfm_top #(.FIFO_DEPTH(16)) i_i2cfm_top (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .scl_i(scl_line), .scl_o, .scl_oe,
    .sda_i(sda_line), .sda_o, .sda_oe, .irq,
    .data_line_drive_select(pad[0]), .data_line_filter_disable(pad[1]),
    .clock_line_drive_select(pad[2]), .clock_line_filter_disable(pad[3])
  );

  i2cfm_bus_model i_i2cfm_bus_model (
    .sda_line(sda_line), .scl_drv(scl_drv), .sda_drv(sda_drv)
  );

  // ****
  // checking and bus tasks
  // ****
  task automatic end_of_test();
    if (fail_count == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_of_test

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %08h expected %08h", $time, got, exp);
    end
  endtask : chk_word

  task automatic chk_bit(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_bit

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d,
                        output logic [1:0] r);
    int   n;
    logic got;
    logic aw_t;
    logic w_t;
    logic b_t;
    n = 0;
    got = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!got) begin
      // handshakes are judged on settled values before the edge
      @(negedge aclk);
      aw_t = s_axi_awvalid && s_axi_awready;
      w_t = s_axi_wvalid && s_axi_wready;
      b_t = (s_axi_bvalid === 1'b1);
      if (b_t) r = s_axi_bresp;
      @(posedge aclk);
      n++;
      if (aw_t) s_axi_awvalid <= 1'b0;
      if (w_t) s_axi_wvalid <= 1'b0;
      if (b_t) begin
        got = 1'b1;
        s_axi_bready <= 1'b0;
      end
      if (n > 50) begin
        fail_count++;
        end_of_test();
      end
    end
  endtask : reg_wr

  task automatic reg_rd(input logic [7:0] a, output logic [31:0] d,
                        output logic [1:0] r);
    int   n;
    logic got;
    logic ar_t;
    logic r_t;
    n = 0;
    got = 1'b0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!got) begin
      @(negedge aclk);
      ar_t = s_axi_arvalid && s_axi_arready;
      r_t = (s_axi_rvalid === 1'b1);
      if (r_t) begin
        d = s_axi_rdata;
        r = s_axi_rresp;
      end
      @(posedge aclk);
      n++;
      if (ar_t) s_axi_arvalid <= 1'b0;
      if (r_t) begin
        got = 1'b1;
        s_axi_rready <= 1'b0;
      end
      if (n > 50) begin
        fail_count++;
        end_of_test();
      end
    end
  endtask : reg_rd

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_wr(a, d, rsp);
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    reg_rd(a, rd, rsp);
    chk_word(rd, e);
  endtask : rd_chk

  task automatic frame(input logic [7:0] b, output logic a);
    i_i2cfm_bus_model.start_frame();
    i_i2cfm_bus_model.send_byte(b, a);
    i_i2cfm_bus_model.stop_frame();
    repeat (8) @(posedge aclk);
  endtask : frame

  // ****
  // scenarios
  // ****
  initial begin
    repeat (100000) @(posedge aclk);
    fail_count++;
    end_of_test();
  end

  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk_word({28'h0, pad}, 32'h0);
    rd_chk(OFS_PAD, 32'h0);
    chk_bit(irq, 1'b0);
    for (int i = 0; i < 4; i++) begin
      wr(OFS_PAD, 32'h1 << i);
      @(posedge aclk);
      chk_word({28'h0, pad}, 32'h1 << i);
      rd_chk(OFS_PAD, 32'h1 << i);
    end
    wr(OFS_PAD, 32'h0);
    reg_wr(8'h40, 32'hA5, rsp);
    chk_word({30'h0, rsp}, {30'h0, RESP_SLVERR});
    reg_rd(8'h40, rd, rsp);
    chk_word({30'h0, rsp}, {30'h0, RESP_SLVERR});
    wr(OFS_MON, 32'h5);
    for (int k = 0; k < 4; k++) begin
      wr(OFS_ADR0 + 8'(4*k), {24'h0, adr_tab[k], 1'b1});
      wr(OFS_MSK0 + 8'(4*k), 32'h0);
      rd_chk(OFS_ADR0 + 8'(4*k), {24'h0, adr_tab[k], 1'b1});
      frame({adr_tab[k], 1'b0}, ack);
      chk_bit(ack, 1'b0);
      chk_bit(irq, 1'b1);
      rd_chk(OFS_LAST, {24'h0, adr_tab[k], 1'b0});
      wr(OFS_STAT, 32'h1);
      @(posedge aclk);
      chk_bit(irq, 1'b0);
    end
    frame(8'h00, ack);
    chk_bit(ack, 1'b0);
    chk_bit(irq, 1'b1);
    wr(OFS_STAT, 32'h1);
    wr(OFS_MON, 32'h1);
    frame(8'h00, ack);
    chk_bit(ack, 1'b1);
    frame(8'hAA, ack);
    chk_bit(ack, 1'b1);
    chk_bit(irq, 1'b0);
    wr(OFS_MSK0, 32'h2);
    rd_chk(OFS_MSK0, 32'h2);
    frame({7'h13, 1'b0}, ack);
    chk_bit(ack, 1'b0);
    frame({7'h12, 1'b1}, ack);
    chk_bit(ack, 1'b1);
    wr(OFS_STAT, 32'h3);
    wr(OFS_MON, 32'h3);
    mon_on <= 1'b1;
    frame(8'h58, ack);
    chk_bit(ack, 1'b1);
    chk_bit(irq, 1'b1);
    rd_chk(OFS_DBUF, 32'h158);
    reg_rd(OFS_DBUF, rd, rsp);
    chk_bit(rd[8], 1'b0);
    wr(OFS_STAT, 32'h3);
    i_i2cfm_bus_model.start_frame();
    i_i2cfm_bus_model.send_byte(8'hE1, ack);
    for (int i = 0; i < 16; i++) begin
      i_i2cfm_bus_model.send_byte(8'(i), ack);
      chk_bit(ack, 1'b1);
    end
    i_i2cfm_bus_model.stop_frame();
    repeat (8) @(posedge aclk);
    rd_chk(OFS_STAT, 32'h3);
    rd_chk(OFS_DBUF, 32'h1E1);
    for (int i = 0; i < 15; i++) begin
      rd_chk(OFS_DBUF, 32'h100 | 32'(i));
    end
    reg_rd(OFS_DBUF, rd, rsp);
    chk_bit(rd[8], 1'b0);
    mon_on <= 1'b0;
    @(posedge aclk);
    chk_bit(touched, 1'b0);
    end_of_test();
  end
endmodule : tb_top
